// ---- include/diag_consts.svh ----
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets (16-bit registers, low byte first)
// ---------------------------------------------------------------
`define BOOST_LEVEL_OFFSET      8'h1C
`define STRAP_DETECT_OFFSET     8'h1E

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BOOST_CODE_MSB          10
`define BOOST_CODE_LSB          0
`define LED_PWM_RATE_MSB        14
`define LED_PWM_RATE_LSB        12
`define STRING_LAYOUT_MSB       10
`define STRING_LAYOUT_LSB       8
`define SWITCH_RATE_MSB         5
`define SWITCH_RATE_LSB         3
`define DIM_MODE_MSB            2
`define DIM_MODE_LSB            0
`define DIM_MODE_ADDR_BIT       2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define BOOST_CODE_RESET        11'h000
`define STRAP_CODE_RESET        3'h0
`define BOOST_LEVEL_RESET       16'h0000
`define STRAP_DETECT_RESET      16'h0000

// ---------------------------------------------------------------
// Bus target addresses selected by the dimming strap
// ---------------------------------------------------------------
`define TARGET_ADDR_LOW_MODES   7'h2B
`define TARGET_ADDR_HIGH_MODES  7'h2A

// ---------------------------------------------------------------
// Serial framing
// ---------------------------------------------------------------
`define BITS_PER_BYTE           4'h8
`define LAST_TX_BIT             4'h7

`endif

// ---- include/diag_pkg.sv ----
package diag_pkg;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'b000001,
      ST_RX      = 6'b000010,
      ST_ACK_OUT = 6'b000100,
      ST_TX      = 6'b001000,
      ST_ACK_IN  = 6'b010000,
      ST_WAIT    = 6'b100000
   } serial_state_t;

   typedef enum logic [1:0] {
      PH_ADDR = 2'h0,
      PH_PTR  = 2'h1,
      PH_DATA = 2'h2
   } byte_phase_t;

   typedef enum logic [2:0] {
      PWM_152HZ   = 3'h0,
      PWM_305HZ   = 3'h1,
      PWM_610HZ   = 3'h2,
      PWM_1221HZ  = 3'h3,
      PWM_2441HZ  = 3'h4,
      PWM_4883HZ  = 3'h5,
      PWM_9766HZ  = 3'h6,
      PWM_19531HZ = 3'h7
   } led_pwm_rate_t;

   typedef enum logic [2:0] {
      LAYOUT_6_SEPARATE = 3'h0,
      LAYOUT_5_SEPARATE = 3'h1,
      LAYOUT_4_SEPARATE = 3'h2,
      LAYOUT_3_SEPARATE = 3'h3,
      LAYOUT_2_SEPARATE = 3'h4,
      LAYOUT_3_GROUPS   = 3'h5,
      LAYOUT_2_GROUPS   = 3'h6,
      LAYOUT_1_GROUP    = 3'h7
   } string_layout_t;

   typedef enum logic [2:0] {
      SW_100KHZ  = 3'h0,
      SW_200KHZ  = 3'h1,
      SW_303KHZ  = 3'h2,
      SW_400KHZ  = 3'h3,
      SW_500KHZ  = 3'h4,
      SW_1818KHZ = 3'h5,
      SW_2000KHZ = 3'h6,
      SW_2222KHZ = 3'h7
   } switch_rate_t;

   // Bit 2 of the code selects the bus address, bits 1:0 the dimming
   typedef enum logic [2:0] {
      DIM_PWM_ADDR_B      = 3'h0,
      DIM_HYBRID_ADDR_B   = 3'h1,
      DIM_CONST_ADDR_B    = 3'h2,
      DIM_DIRECT_ADDR_B   = 3'h3,
      DIM_PWM_ADDR_A      = 3'h4,
      DIM_HYBRID_ADDR_A   = 3'h5,
      DIM_CONST_ADDR_A    = 3'h6,
      DIM_DIRECT_ADDR_A   = 3'h7
   } dim_mode_t;

endpackage

// ---- logic/sync2.sv ----
`timescale 1ns/1ns
`default_nettype none

module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,  // System clock
   input  wire logic             rst,       // Async reset, high
   input  wire logic [WIDTH-1:0] async_in,  // Pin level
   output var  logic [WIDTH-1:0] sync_out   // Synchronised level
);

   logic [WIDTH-1:0] meta_reg;

   // Resets high: an idle bus line is high
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= {WIDTH{1'b1}};
         sync_out <= {WIDTH{1'b1}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ---- logic/backlight_diag_readback.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "diag_consts.svh"

// Overview of operation
// RULE1: Boost register bits 10:0 show loop code
// RULE2: Boost bits 15:11 read zero, writes ignored
// RULE3: Detection bits 14:12 give LED PWM rate
// RULE4: Detection bits 10:8 give string layout
// RULE5: Layout codes 5-7 mean grouped outputs
// RULE6: Detection bits 5:3 give switching rate
// RULE7: Detection bits 2:0 give dimming mode
// RULE8: Dimming code bit 2 picks bus address
// RULE9: Detection reserved bits read zero, reset zero
// RULE10: Reads never disturb sources or results
module backlight_diag_readback (
   input  wire logic                     core_clk,        // System clock
   input  wire logic                     rst,             // Async reset
   input  wire logic [10:0]              boost_code_in,   // Loop voltage code
   input  wire logic                     strap_done,      // Detect done pulse
   input  wire diag_pkg::led_pwm_rate_t  pwm_rate_strap,  // Detected PWM rate
   input  wire diag_pkg::string_layout_t string_layout_strap, // Layout
   input  wire diag_pkg::switch_rate_t   switch_rate_strap,   // Boost rate
   input  wire diag_pkg::dim_mode_t      dim_mode_strap,  // Dimming + addr
   input  wire logic                     scl_in,          // Bus clock pin
   input  wire logic                     sda_in,          // Bus data pin
   output logic                          sda_out,         // Data drive level
   output logic                          sda_oe,          // Data pull enable
   output logic [6:0]                    target_addr      // Answered address
);
   import diag_pkg::*;

   // ------------------------------------------------------------
   // Source capture
   // ------------------------------------------------------------
   logic [10:0]    boost_voltage_code_reg;
   led_pwm_rate_t  detected_led_pwm_rate_reg;
   string_layout_t detected_string_layout_reg;
   switch_rate_t   detected_switch_rate_reg;
   dim_mode_t      dim_mode_reg;

   // Only the sources update these; the bus side never writes them
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         boost_voltage_code_reg <= `BOOST_CODE_RESET;                 // RULE1
      end else begin
         boost_voltage_code_reg <= boost_code_in;                     // RULE10
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         detected_led_pwm_rate_reg  <= led_pwm_rate_t'(`STRAP_CODE_RESET);
         detected_string_layout_reg <= string_layout_t'(`STRAP_CODE_RESET);
         detected_switch_rate_reg   <= switch_rate_t'(`STRAP_CODE_RESET);
         dim_mode_reg               <= dim_mode_t'(`STRAP_CODE_RESET); // RULE9
      end else if (strap_done) begin
         detected_led_pwm_rate_reg  <= pwm_rate_strap;                // RULE3
         detected_string_layout_reg <= string_layout_strap;    // RULE4 RULE5
         detected_switch_rate_reg   <= switch_rate_strap;             // RULE6
         dim_mode_reg               <= dim_mode_strap;                // RULE7
      end
   end

   // ------------------------------------------------------------
   // Register images
   // ------------------------------------------------------------
   wire [15:0] boost_level_readback;
   wire [15:0] strap_detect_readback;

   assign boost_level_readback = {5'h00, boost_voltage_code_reg}; // RULE1 RULE2
   assign strap_detect_readback = {1'b0, detected_led_pwm_rate_reg,
                                   1'b0, detected_string_layout_reg,
                                   2'b00, detected_switch_rate_reg,
                                   dim_mode_reg};                     // RULE9

   // Until detection finishes the code is zero, so 0x2B is answered
   assign target_addr = dim_mode_reg[`DIM_MODE_ADDR_BIT] ?
                        `TARGET_ADDR_HIGH_MODES :
                        `TARGET_ADDR_LOW_MODES;                       // RULE8

   // ------------------------------------------------------------
   // Bus pin conditioning
   // ------------------------------------------------------------
   logic [1:0] pins_sync;
   logic       scl_d_reg;
   logic       sda_d_reg;

   sync2 #(.WIDTH(2)) u_pin_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in ({scl_in, sda_in}),
      .sync_out (pins_sync)
   );

   wire scl_s = pins_sync[1];
   wire sda_s = pins_sync[0];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   wire scl_rise  = scl_s & ~scl_d_reg;
   wire scl_fall  = ~scl_s & scl_d_reg;
   wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ------------------------------------------------------------
   // Read data selection
   // ------------------------------------------------------------
   logic [7:0] ptr_reg;
   logic [7:0] ptr_next;

   wire [6:0] ptr_word  = ptr_reg[7:1];
   wire [7:0] boost_ptr = `BOOST_LEVEL_OFFSET;
   wire [7:0] strap_ptr = `STRAP_DETECT_OFFSET;
   // Both bytes of a register share one word index
   wire       hit_boost = (ptr_word == boost_ptr[7:1]);
   wire       hit_strap = (ptr_word == strap_ptr[7:1]);
   wire [15:0] rd_word  = hit_boost ? boost_level_readback :
                          hit_strap ? strap_detect_readback : 16'h0000;
   // Unmapped offsets read as zero
   wire [7:0] rd_byte   = ptr_reg[0] ? rd_word[15:8] : rd_word[7:0];

   // ------------------------------------------------------------
   // Serial target engine
   // ------------------------------------------------------------
   serial_state_t state_reg;
   serial_state_t state_next;
   byte_phase_t   phase_reg;
   byte_phase_t   phase_next;
   logic [3:0]    bit_cnt_reg;
   logic [3:0]    bit_cnt_next;
   logic [7:0]    shift_reg;
   logic [7:0]    shift_next;
   logic          rw_reg;
   logic          rw_next;
   logic          nack_reg;
   logic          nack_next;
   logic          oe_reg;
   logic          oe_next;

   always_comb begin
      state_next   = state_reg;
      phase_next   = phase_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next   = shift_reg;
      rw_next      = rw_reg;
      nack_next    = nack_reg;
      oe_next      = oe_reg;
      ptr_next     = ptr_reg;
      if (bus_start) begin
         state_next   = ST_RX;
         phase_next   = PH_ADDR;
         bit_cnt_next = 4'h0;
         oe_next      = 1'b0;
      end else if (bus_stop) begin
         state_next = ST_IDLE;
         oe_next    = 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
            end
            ST_RX: begin
               if (scl_rise && bit_cnt_reg != `BITS_PER_BYTE) begin
                  shift_next   = {shift_reg[6:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
                  state_next = ST_ACK_OUT;
                  oe_next    = 1'b1;
                  unique case (phase_reg)
                     PH_ADDR: begin
                        rw_next = shift_reg[0];
                        if (shift_reg[7:1] != target_addr) begin // RULE8
                           state_next = ST_WAIT;
                           oe_next    = 1'b0;
                        end
                     end
                     PH_PTR:  ptr_next = shift_reg;
                     // Data bytes are acknowledged and dropped
                     PH_DATA: ptr_next = ptr_reg + 8'h01;          // RULE2
                     default: begin
                        state_next = ST_WAIT;
                        oe_next    = 1'b0;
                     end
                  endcase
               end
            end
            ST_ACK_OUT: begin
               if (scl_fall) begin
                  bit_cnt_next = 4'h0;
                  oe_next      = 1'b0;
                  state_next   = ST_RX;
                  if (phase_reg == PH_ADDR && rw_reg) begin
                     state_next = ST_TX;
                     shift_next = rd_byte;                          // RULE10
                     oe_next    = ~rd_byte[7];
                  end else if (phase_reg == PH_ADDR) begin
                     phase_next = PH_PTR;
                  end else begin
                     phase_next = PH_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == `LAST_TX_BIT) begin
                     state_next = ST_ACK_IN;
                     oe_next    = 1'b0;
                     ptr_next   = ptr_reg + 8'h01;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next    = ~shift_reg[6];
                  end
               end
            end
            ST_ACK_IN: begin
               if (scl_rise) begin
                  nack_next = sda_s;
               end else if (scl_fall) begin
                  if (nack_reg) begin
                     state_next = ST_WAIT;
                  end else begin
                     state_next   = ST_TX;
                     bit_cnt_next = 4'h0;
                     shift_next   = rd_byte;
                     oe_next      = ~rd_byte[7];
                  end
               end
            end
            ST_WAIT: begin
            end
            default: begin
               state_next = ST_IDLE;
               oe_next    = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg   <= ST_IDLE;
         phase_reg   <= PH_ADDR;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         rw_reg      <= 1'b0;
         nack_reg    <= 1'b0;
         oe_reg      <= 1'b0;
         ptr_reg     <= 8'h00;
      end else begin
         state_reg   <= state_next;
         phase_reg   <= phase_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg   <= shift_next;
         rw_reg      <= rw_next;
         nack_reg    <= nack_next;
         oe_reg      <= oe_next;
         ptr_reg     <= ptr_next;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = oe_reg;

endmodule

`default_nettype wire

// ---- verif/diag_readback_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none

module diag_readback_monitor (
   input  wire logic                core_clk,       // System clock
   input  wire logic                rst,            // Async reset
   input  wire logic                strap_done,     // Detect done pulse
   input  wire diag_pkg::dim_mode_t dim_mode_strap, // Dimming + addr
   input  wire logic                scl_in,         // Bus clock pin
   input  wire logic                sda_out,        // Data drive level
   input  wire logic                sda_oe,         // Data pull enable
   input  wire logic [6:0]          target_addr     // Answered address
);
   import diag_pkg::*;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_addr_low_mode : assert property (
      strap_done && !dim_mode_strap[2] |=> target_addr == 7'h2B)
      else $error("address not 0x2B after low mode code");
   a_addr_high_mode : assert property (
      strap_done && dim_mode_strap[2] |=> target_addr == 7'h2A)
      else $error("address not 0x2A after high mode code");
   a_addr_only_latch : assert property (
      $changed(target_addr) |-> $past(strap_done))
      else $error("address moved without a detect pulse");
   a_addr_reset_val : assert property (
      disable iff (1'b0) rst |-> target_addr == 7'h2B)
      else $error("address not 0x2B in reset");
   a_oe_reset_off : assert property (
      disable iff (1'b0) rst |-> !sda_oe)
      else $error("data line pulled during reset");
   a_drive_level_zero : assert property (
      sda_out == 1'b0)
      else $error("open-drain level not low");
   // Data may only move while the bus clock is low
   a_oe_scl_low : assert property (
      $changed(sda_oe) |-> !scl_in)
      else $error("data line moved while clock high");
   a_oe_bit_hold : assert property (
      $rose(sda_oe) |-> sda_oe [*8])
      else $error("data pull shorter than one bit");
endmodule

`default_nettype wire

// ---- verif/i2c_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Controller side; the line has a pull-up, so release reads high
module i2c_host_model (
   input  wire logic core_clk,  // System clock
   input  wire logic sda_line,  // Resolved data line
   output var  logic scl,       // Bus clock drive
   output var  logic sda_low    // High = pull data low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Ten cycles per phase keeps well above the four-cycle minimum
   task automatic half();
      repeat (10) @(negedge core_clk);
   endtask

   task automatic start();
      sda_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl = 1'b0;
   endtask

   task automatic stop();
      sda_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask

   task automatic bit_out(input logic b);
      sda_low = !b;
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
   endtask

   task automatic bit_in(output logic r);
      sda_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      r = sda_line;
      scl = 1'b0;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(r);
      ack = !r;
   endtask

   task automatic rd_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(last);
   endtask
endmodule

`default_nettype wire

// ---- verif/tb_backlight_diag_readback.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_backlight_diag_readback;
   import diag_pkg::*;

   typedef struct packed {
      logic [2:0]  p, l, s, m;
      logic [10:0] b;
      logic [15:0] det;
      logic [6:0]  adr;
   } row_t;

   logic           core_clk, rst, strap_done, scl, sda_low;
   logic [10:0]    boost_code_in;
   led_pwm_rate_t  pwm_rate_strap;
   string_layout_t string_layout_strap;
   switch_rate_t   switch_rate_strap;
   dim_mode_t      dim_mode_strap;
   logic           sda_out, sda_oe, ok;
   logic [6:0]     target_addr;
   logic [31:0]    w;
   int             err_total, num_checks;
   wire            sda_line = !(sda_low || (sda_oe && !sda_out));

   // Every code of every strap field, address flips at mode 4
   row_t rows [8] = '{
      '{3'h0, 3'h7, 3'h2, 3'h0, 11'h7FF, 16'h0710, 7'h2B},
      '{3'h1, 3'h6, 3'h3, 3'h1, 11'h400, 16'h1619, 7'h2B},
      '{3'h2, 3'h5, 3'h4, 3'h2, 11'h001, 16'h2522, 7'h2B},
      '{3'h3, 3'h4, 3'h5, 3'h3, 11'h2AA, 16'h342B, 7'h2B},
      '{3'h4, 3'h3, 3'h6, 3'h4, 11'h555, 16'h4334, 7'h2A},
      '{3'h5, 3'h2, 3'h7, 3'h5, 11'h0F0, 16'h523D, 7'h2A},
      '{3'h6, 3'h1, 3'h0, 3'h6, 11'h000, 16'h6106, 7'h2A},
      '{3'h7, 3'h0, 3'h1, 3'h7, 11'h123, 16'h700F, 7'h2A}};

   backlight_diag_readback dut_u (
      .core_clk(core_clk), .rst(rst), .boost_code_in(boost_code_in),
      .strap_done(strap_done), .pwm_rate_strap(pwm_rate_strap),
      .string_layout_strap(string_layout_strap),
      .switch_rate_strap(switch_rate_strap),
      .dim_mode_strap(dim_mode_strap), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .target_addr(target_addr));

   i2c_host_model host_u (
      .core_clk(core_clk), .sda_line(sda_line), .scl(scl),
      .sda_low(sda_low));

   task automatic tally_and_finish();
      if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   // Reads four bytes from pointer p, low byte first
   task automatic rd4(input logic [6:0] a, input logic [7:0] p,
                      output logic [31:0] v, output logic good);
      logic k0, k1, k2;
      logic [7:0] d;
      host_u.start();
      host_u.wr_byte({a, 1'b0}, k0);
      host_u.wr_byte(p, k1);
      host_u.start();
      host_u.wr_byte({a, 1'b1}, k2);
      for (int i = 0; i < 4; i++) begin
         host_u.rd_byte(i == 3, d);
         v[8*i +: 8] = d;
      end
      host_u.stop();
      good = k0 && k1 && k2;
   endtask

   task automatic wr2(input logic [6:0] a, input logic [7:0] p,
                      input logic [15:0] d);
      logic k;
      host_u.start();
      host_u.wr_byte({a, 1'b0}, k);
      host_u.wr_byte(p, k);
      host_u.wr_byte(d[7:0], k);
      host_u.wr_byte(d[15:8], k);
      host_u.stop();
   endtask

   task automatic apply(input row_t r);
      @(negedge core_clk);
      boost_code_in = r.b;
      pwm_rate_strap = led_pwm_rate_t'(r.p);
      string_layout_strap = string_layout_t'(r.l);
      switch_rate_strap = switch_rate_t'(r.s);
      dim_mode_strap = dim_mode_t'(r.m);
      strap_done = 1'b1;
      @(negedge core_clk);
      strap_done = 1'b0;
      @(negedge core_clk);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      rst = 1'b1;
      apply('0);
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      repeat (5) @(negedge core_clk);
      chk("reset_addr", 32'h2B, 32'(target_addr));
      rd4(7'h2B, 8'h1C, w, ok);
      chk("reset_regs", 32'h0, w);
      // ---------------------------------------------------------------
      // Table of strap and loop codes
      // ---------------------------------------------------------------
      foreach (rows[i]) begin
         apply(rows[i]);
         chk("addr", 32'(rows[i].adr), 32'(target_addr));
         rd4(rows[i].adr, 8'h1C, w, ok);
         chk("ack", 32'h1, 32'(ok));
         chk("regs", {rows[i].det, 5'h00, rows[i].b}, w);
         // Same compare covers layout, switch, mode and reserved zeros
         chk("fields", {rows[i].det, 5'h00, rows[i].b}, w);
      end
      // ---------------------------------------------------------------
      // Hand-written cases
      // ---------------------------------------------------------------
      rd4(7'h2B, 8'h1C, w, ok);
      chk("wrong_addr", 32'h0, 32'(ok));
      // A target that is not addressed leaves the line to its pull-up
      chk("wrong_addr_idle", 32'hFFFF_FFFF, w);
      wr2(7'h2A, 8'h1C, 16'hFFFF);
      wr2(7'h2A, 8'h1E, 16'hFFFF);
      rd4(7'h2A, 8'h1C, w, ok);
      chk("after_write", 32'h700F_0123, w);
      @(negedge core_clk);
      pwm_rate_strap = PWM_152HZ;
      dim_mode_strap = DIM_PWM_ADDR_B;
      boost_code_in = 11'h7FE;
      rd4(7'h2A, 8'h1C, w, ok);
      chk("live_boost", 32'h700F_07FE, w);
      rd4(7'h2A, 8'h1C, w, ok);
      chk("reread", 32'h700F_07FE, w);
      rd4(7'h2A, 8'h10, w, ok);
      chk("unmapped", 32'h0, w);
      @(negedge core_clk);
      boost_code_in = 11'h000;
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("midrun_addr", 32'h2B, 32'(target_addr));
      rst = 1'b0;
      repeat (5) @(negedge core_clk);
      rd4(7'h2B, 8'h1C, w, ok);
      chk("midrun_regs", 32'h0, w);
      tally_and_finish();
   end
endmodule

bind backlight_diag_readback diag_readback_monitor mon_u (
   .core_clk(core_clk), .rst(rst), .strap_done(strap_done),
   .dim_mode_strap(dim_mode_strap), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .target_addr(target_addr));

`default_nettype wire
